// ==== hw/bspp_defines.vh ====
// constants for the buffered serial port pin block
// Notes on behaviour
// - receiver shifts bits on receive clock edges
// - receive clock driven when its direction bit set
// - receive pins become general-purpose when enabled
// - transmit shifts on transmit clock; bit 0 input
// - software reads transmit clock pin level
// - transmit pins become general-purpose when enabled
// - output-off low floats all transmit pins
// - receive frame-sync pulse starts each received word
// - transmit frame-sync pulse starts each sent word
// - reset returns transmit frame sync to input
`ifndef BSPP_DEFINES_VH
`define BSPP_DEFINES_VH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define BSPP_ADDR_W        5
`define BSPP_ADDR_CTRL     5'h00
`define BSPP_ADDR_PCR      5'h04
`define BSPP_ADDR_TXDATA   5'h08
`define BSPP_ADDR_RXDATA   5'h0C
`define BSPP_ADDR_CLKDIV   5'h10
// ---------------------------------------------
// serial_port_control_reg fields
// ---------------------------------------------
`define BSPP_CTRL_RXEN     0
`define BSPP_CTRL_TXEN     1
`define BSPP_CTRL_TXCLKLVL 4
`define BSPP_CTRL_RXCLKLVL 5
`define BSPP_CTRL_TXBUSY   8
`define BSPP_CTRL_RXVALID  9
`define BSPP_CTRL_FIFOFULL 10
`define BSPP_CTRL_OVERRUN  11
// ---------------------------------------------
// pin_control_reg fields
// ---------------------------------------------
`define BSPP_PCR_RXCLKDIR  0
`define BSPP_PCR_TXCLKDIR  1
`define BSPP_PCR_TXFSDIR   3
`define BSPP_PCR_RXGPIO    4
`define BSPP_PCR_TXGPIO    5
`define BSPP_PCR_DIR_LSB   8
`define BSPP_PCR_OUT_LSB   16
`define BSPP_PCR_IN_LSB    24
// ---------------------------------------------
// sizes and reset values
// ---------------------------------------------
`define BSPP_WORD_W        16
`define BSPP_CNT_W         5
`define BSPP_WORD_BITS     5'h10
`define BSPP_FIFO_DEPTH    16
`define BSPP_FIFO_AW       4
`define BSPP_CLKDIV_RST    8'h04
`define BSPP_RESP_OKAY     2'h0
`define BSPP_RESP_SLVERR   2'h2
`endif

// ==== hw/bspp_fifo.v ====
// synchronous first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
module bspp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wrPtr;
  reg [AW:0]      rdPtr;
  wire            empty = (wrPtr == rdPtr);
  wire            full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);

  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  always @(posedge ref_clk) begin
    if (inValid && !full) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wrPtr <= {(AW+1){1'b0}};
      rdPtr <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule // bspp_fifo

// ==== hw/bspp_top.v ====
// buffered serial port pins with register slave, shifters and transmit buffer
`timescale 1ns/10ps
`include "bspp_defines.vh"
module bspp_top (
  input  wire                    ref_clk,
  input  wire                    rst,
  input  wire [`BSPP_ADDR_W-1:0] s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`BSPP_ADDR_W-1:0] s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  input  wire                    rxShiftClockIn,
  output reg                     rxShiftClockOut,
  output reg                     rxShiftClockOe,
  input  wire                    rxSerialIn,
  input  wire                    rxFrameSyncIn,
  output reg                     rxFrameSyncOut,
  output reg                     rxFrameSyncOe,
  input  wire                    txShiftClockIn,
  output reg                     txShiftClockOut,
  output reg                     txShiftClockOe,
  input  wire                    txSerialOutIn,
  output reg                     txSerialOut,
  output reg                     txSerialOutOe,
  input  wire                    txFrameSyncIn,
  output reg                     txFrameSyncOut,
  output reg                     txFrameSyncOe,
  input  wire                    outputOffN
);
  localparam TX_IDLE  = 2'h0;
  localparam TX_SYNC  = 2'h1;
  localparam TX_SHIFT = 2'h2;
  localparam RX_IDLE  = 1'b0;
  localparam RX_SHIFT = 1'b1;

  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  // index: 0 rx clk, 1 rx data, 2 rx fs, 3 tx clk, 4 tx data, 5 tx fs, 6 output-off
  wire [6:0] pinRaw = {outputOffN, txFrameSyncIn, txSerialOutIn, txShiftClockIn,
                       rxFrameSyncIn, rxSerialIn, rxShiftClockIn};
  wire [6:0] pinSync;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
      reg meta;
      reg sync;
      always @(posedge ref_clk) begin
        if (rst) begin
          meta <= 1'b0;
          sync <= 1'b0;
        end else begin
          meta <= pinRaw[gi];
          sync <= meta;
        end
      end
      assign pinSync[gi] = sync;
    end
  endgenerate

  wire offSync = pinSync[6];

  // ---------------------------------------------
  // control state
  // ---------------------------------------------
  reg        rxEnable;
  reg        txEnable;
  reg        rxClkDir;
  reg        txClkDir;
  reg        txFsDir;
  reg        rxGpio;
  reg        txGpio;
  reg [5:0]  gpioDir;
  reg [5:0]  gpioOut;
  reg [7:0]  clkDiv;
  reg [`BSPP_WORD_W-1:0] rxWord;
  reg        rxValid;
  reg        overrun;

  wire       rxActive = rxEnable & ~rxGpio;
  wire       txActive = txEnable & ~txGpio;

  // ---------------------------------------------
  // internal shift clock divider
  // ---------------------------------------------
  reg [7:0] divCnt;
  reg       genClk;

  always @(posedge ref_clk) begin
    if (rst) begin
      divCnt <= 8'h00;
      genClk <= 1'b0;
    end else if (divCnt >= clkDiv) begin
      divCnt <= 8'h00;
      genClk <= ~genClk;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // ---------------------------------------------
  // shift clock edge detection
  // ---------------------------------------------
  wire rxClkLvl = rxClkDir ? genClk : pinSync[0];
  wire txClkLvl = txClkDir ? genClk : pinSync[3];
  reg  rxClkPrev;
  reg  txClkPrev;

  always @(posedge ref_clk) begin
    if (rst) begin
      rxClkPrev <= 1'b0;
      txClkPrev <= 1'b0;
    end else begin
      rxClkPrev <= rxClkLvl;
      txClkPrev <= txClkLvl;
    end
  end

  wire rxRise = rxClkLvl & ~rxClkPrev;
  wire txRise = txClkLvl & ~txClkPrev;
  wire txFall = ~txClkLvl & txClkPrev;

  // ---------------------------------------------
  // transmit buffer
  // ---------------------------------------------
  wire [`BSPP_WORD_W-1:0] fifoOutData;
  wire                    fifoOutValid;
  wire                    fifoInReady;
  reg                     fifoPop;
  wire                    fifoPush;
  wire [`BSPP_WORD_W-1:0] fifoInData;

  bspp_fifo #(
    .WIDTH (`BSPP_WORD_W),
    .DEPTH (`BSPP_FIFO_DEPTH),
    .AW    (`BSPP_FIFO_AW)
  ) u_txFifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inData   (fifoInData),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  // ---------------------------------------------
  // transmitter
  // ---------------------------------------------
  reg [1:0]              txState;
  reg [`BSPP_WORD_W-1:0] txShift;
  reg [`BSPP_CNT_W-1:0]  txCnt;
  reg                    txBit;
  reg                    txFsGen;

  // frame sync generated on a falling edge when driven, caught on a rising edge otherwise
  wire txStartOut = txFsDir & txFall;
  wire txStartIn  = ~txFsDir & txRise & pinSync[5];

  always @* begin
    fifoPop = (txState == TX_IDLE) & txActive & fifoOutValid & (txStartOut | txStartIn);
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      txState <= TX_IDLE;
      txShift <= {`BSPP_WORD_W{1'b0}};
      txCnt   <= {`BSPP_CNT_W{1'b0}};
      txBit   <= 1'b0;
      txFsGen <= 1'b0;
    end else begin
      case (txState)
        TX_IDLE: begin
          if (fifoPop) begin
            txShift <= fifoOutData;
            txFsGen <= txFsDir;
            txState <= TX_SYNC;
          end
        end
        TX_SYNC: begin
          if (txFall) begin
            txFsGen <= 1'b0;
            txBit   <= txShift[`BSPP_WORD_W-1];
            txShift <= {txShift[`BSPP_WORD_W-2:0], 1'b0};
            txCnt   <= 5'h01;
            txState <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (txFall) begin
            if (txCnt == `BSPP_WORD_BITS) begin
              txBit   <= 1'b0;
              txState <= TX_IDLE;
            end else begin
              txBit   <= txShift[`BSPP_WORD_W-1];
              txShift <= {txShift[`BSPP_WORD_W-2:0], 1'b0};
              txCnt   <= txCnt + 5'h01;
            end
          end
        end
        default: begin
          txState <= TX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // receiver
  // ---------------------------------------------
  reg                    rxState;
  reg [`BSPP_WORD_W-1:0] rxShift;
  reg [`BSPP_CNT_W-1:0]  rxCnt;
  reg                    rxDone;

  always @(posedge ref_clk) begin
    if (rst) begin
      rxState <= RX_IDLE;
      rxShift <= {`BSPP_WORD_W{1'b0}};
      rxCnt   <= {`BSPP_CNT_W{1'b0}};
      rxDone  <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      case (rxState)
        RX_IDLE: begin
          if (rxActive && rxRise && pinSync[2]) begin
            rxCnt   <= 5'h00;
            rxState <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rxRise) begin
            rxShift <= {rxShift[`BSPP_WORD_W-2:0], pinSync[1]};
            rxCnt   <= rxCnt + 5'h01;
            if (rxCnt == `BSPP_WORD_BITS - 5'h01) begin
              rxDone  <= 1'b1;
              rxState <= RX_IDLE;
            end
          end
        end
        default: begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // register read mux
  // ---------------------------------------------
  function [31:0] regRead;
    input [`BSPP_ADDR_W-1:0] addr;
    reg   [31:0]             v;
    begin
      v = 32'h0000_0000;
      case (addr)
        `BSPP_ADDR_CTRL: begin
          v[`BSPP_CTRL_RXEN]     = rxEnable;
          v[`BSPP_CTRL_TXEN]     = txEnable;
          v[`BSPP_CTRL_TXCLKLVL] = pinSync[3];
          v[`BSPP_CTRL_RXCLKLVL] = pinSync[0];
          v[`BSPP_CTRL_TXBUSY]   = (txState != TX_IDLE);
          v[`BSPP_CTRL_RXVALID]  = rxValid;
          v[`BSPP_CTRL_FIFOFULL] = ~fifoInReady;
          v[`BSPP_CTRL_OVERRUN]  = overrun;
        end
        `BSPP_ADDR_PCR: begin
          v[`BSPP_PCR_RXCLKDIR] = rxClkDir;
          v[`BSPP_PCR_TXCLKDIR] = txClkDir;
          v[`BSPP_PCR_TXFSDIR]  = txFsDir;
          v[`BSPP_PCR_RXGPIO]   = rxGpio;
          v[`BSPP_PCR_TXGPIO]   = txGpio;
          v[`BSPP_PCR_DIR_LSB +: 6] = gpioDir;
          v[`BSPP_PCR_OUT_LSB +: 6] = gpioOut;
          v[`BSPP_PCR_IN_LSB +: 6]  = pinSync[5:0];
        end
        `BSPP_ADDR_RXDATA: v[`BSPP_WORD_W-1:0] = rxWord;
        `BSPP_ADDR_CLKDIV: v[7:0] = clkDiv;
        default: v = 32'h0000_0000;
      endcase
      regRead = v;
    end
  endfunction

  function mapped;
    input [`BSPP_ADDR_W-1:0] addr;
    begin
      mapped = (addr == `BSPP_ADDR_CTRL) || (addr == `BSPP_ADDR_PCR) ||
               (addr == `BSPP_ADDR_TXDATA) || (addr == `BSPP_ADDR_RXDATA) ||
               (addr == `BSPP_ADDR_CLKDIV);
    end
  endfunction

  // ---------------------------------------------
  // register bus slave
  // ---------------------------------------------
  reg [`BSPP_ADDR_W-1:0] awAddr;
  reg                    awHeld;
  reg [31:0]             wData;
  reg [3:0]              wStrb;
  reg                    wHeld;

  wire [31:0] strbMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  wire [31:0] wMerged  = (regRead(awAddr) & ~strbMask) | (wData & strbMask);
  wire        isTx     = (awAddr == `BSPP_ADDR_TXDATA);
  // a full buffer holds the write response back rather than dropping the word
  wire        doWrite  = awHeld & wHeld & ~s_axi_bvalid & ~(isTx & ~fifoInReady);
  wire        rdTake   = s_axi_arvalid & s_axi_arready;
  wire        rxRead   = rdTake & ({s_axi_araddr[`BSPP_ADDR_W-1:2], 2'h0} == `BSPP_ADDR_RXDATA);

  assign fifoPush   = doWrite & isTx;
  assign fifoInData = wMerged[`BSPP_WORD_W-1:0];

  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BSPP_RESP_OKAY;
      awAddr        <= {`BSPP_ADDR_W{1'b0}};
      awHeld        <= 1'b0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      wHeld         <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr        <= {s_axi_awaddr[`BSPP_ADDR_W-1:2], 2'h0};
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr) ? `BSPP_RESP_OKAY : `BSPP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BSPP_RESP_OKAY;
    end else begin
      if (rdTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= regRead({s_axi_araddr[`BSPP_ADDR_W-1:2], 2'h0});
        s_axi_rresp   <= mapped({s_axi_araddr[`BSPP_ADDR_W-1:2], 2'h0}) ?
                         `BSPP_RESP_OKAY : `BSPP_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // register file
  // ---------------------------------------------
  wire wrCtrl = doWrite & (awAddr == `BSPP_ADDR_CTRL);
  wire wrPcr  = doWrite & (awAddr == `BSPP_ADDR_PCR);
  wire wrDiv  = doWrite & (awAddr == `BSPP_ADDR_CLKDIV);

  always @(posedge ref_clk) begin
    if (rst) begin
      rxEnable <= 1'b0;
      txEnable <= 1'b0;
      rxClkDir <= 1'b0;
      txClkDir <= 1'b0;
      txFsDir  <= 1'b0;
      rxGpio   <= 1'b0;
      txGpio   <= 1'b0;
      gpioDir  <= 6'h00;
      gpioOut  <= 6'h00;
      clkDiv   <= `BSPP_CLKDIV_RST;
      rxWord   <= {`BSPP_WORD_W{1'b0}};
      rxValid  <= 1'b0;
      overrun  <= 1'b0;
    end else begin
      if (wrCtrl) begin
        rxEnable <= wMerged[`BSPP_CTRL_RXEN];
        txEnable <= wMerged[`BSPP_CTRL_TXEN];
      end
      if (wrPcr) begin
        rxClkDir <= wMerged[`BSPP_PCR_RXCLKDIR];
        txClkDir <= wMerged[`BSPP_PCR_TXCLKDIR];
        txFsDir  <= wMerged[`BSPP_PCR_TXFSDIR];
        rxGpio   <= wMerged[`BSPP_PCR_RXGPIO];
        txGpio   <= wMerged[`BSPP_PCR_TXGPIO];
        gpioDir  <= wMerged[`BSPP_PCR_DIR_LSB +: 6];
        gpioOut  <= wMerged[`BSPP_PCR_OUT_LSB +: 6];
      end
      if (wrDiv) begin
        clkDiv <= wMerged[7:0];
      end
      // new word beats the read that clears the flag
      if (rxDone) begin
        rxWord  <= rxShift;
        rxValid <= 1'b1;
      end else if (rxRead) begin
        rxValid <= 1'b0;
      end
      if (rxDone && rxValid && !rxRead) begin
        overrun <= 1'b1;
      end else if (wrCtrl && wData[`BSPP_CTRL_OVERRUN] && wStrb[1]) begin
        overrun <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // pin drivers
  // ---------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      rxShiftClockOut <= 1'b0;
      rxShiftClockOe  <= 1'b0;
      rxFrameSyncOut  <= 1'b0;
      rxFrameSyncOe   <= 1'b0;
      txShiftClockOut <= 1'b0;
      txShiftClockOe  <= 1'b0;
      txSerialOut     <= 1'b0;
      txSerialOutOe   <= 1'b0;
      txFrameSyncOut  <= 1'b0;
      txFrameSyncOe   <= 1'b0;
    end else begin
      rxShiftClockOe  <= rxGpio ? gpioDir[0] : rxClkDir;
      rxShiftClockOut <= rxGpio ? gpioOut[0] : genClk;
      rxFrameSyncOe   <= rxGpio & gpioDir[2];
      rxFrameSyncOut  <= gpioOut[2];
      txShiftClockOe  <= offSync & (txGpio ? gpioDir[3] : txClkDir);
      txShiftClockOut <= txGpio ? gpioOut[3] : genClk;
      txSerialOutOe   <= offSync & (txGpio ? gpioDir[4] : 1'b1);
      txSerialOut     <= txGpio ? gpioOut[4] : txBit;
      txFrameSyncOe   <= offSync & (txGpio ? gpioDir[5] : txFsDir);
      txFrameSyncOut  <= txGpio ? gpioOut[5] : txFsGen;
    end
  end
endmodule // bspp_top

// ==== verif/bspp_chk.sv ====
// assertion checker on the pin block ports
`timescale 1ns/10ps
module bspp_chk (
  input logic        ref_clk,
  input logic        rst,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        txShiftClockOe,
  input logic        txSerialOutOe,
  input logic        txFrameSyncOe,
  input logic        outputOffN
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // off input passes two sync stages, so four low samples must float the pins
  chk_off_float: assert property (!outputOffN [*4] |->
    !(txShiftClockOe || txSerialOutOe || txFrameSyncOe)) else $error("tx pin driven while off");
  chk_fs_reset: assert property (disable iff (1'b0) rst |=> !txFrameSyncOe)
    else $error("tx frame sync still driven after reset");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
  chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not released");
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule // bspp_chk

// ==== verif/bspp_peer.sv ====
// behavioural serial peer: sends receive frames, collects transmit words
`timescale 1ns/10ps
module bspp_peer (
  input  wire         txClk,
  input  wire         txFs,
  input  wire         txDat,
  output logic        rxClk,
  output logic        rxFs,
  output logic        rxDat,
  output logic [15:0] gotWord,
  output logic        gotFlag
);
  integer cnt = 0;
  initial begin
    rxClk = 1'b1;
    rxFs = 1'b0;
    rxDat = 1'b0;
    gotWord = 16'h0000;
    gotFlag = 1'b0;
  end
  // clock stands high between frames; released data shows the opposite level
  task automatic send(input logic [15:0] w);
    integer i;
    #5 rxClk = 1'b0;
    rxFs = 1'b1;
    #80 rxClk = 1'b1;
    for (i = 15; i >= 0; i--) begin
      #80 rxClk = 1'b0;
      rxFs = 1'b0;
      rxDat = w[i];
      #80 rxClk = 1'b1;
    end
    #75 rxDat = ~rxDat;
  endtask
  always @(posedge txClk) begin
    gotFlag = 1'b0;
    if (cnt != 0) begin
      gotWord = {gotWord[14:0], txDat};
      cnt = cnt - 1;
      gotFlag = (cnt == 0);
    end else if (txFs) begin
      cnt = 16;
    end
  end
endmodule // bspp_peer

// ==== verif/bspp_top_test.sv ====
// self-checking bench for the serial port pin block
`timescale 1ns/10ps
`include "bspp_defines.vh"
bind bspp_top bspp_chk u_chk (.ref_clk, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .txShiftClockOe, .txSerialOutOe, .txFrameSyncOe, .outputOffN);
module bspp_top_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        outputOffN;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         rxShiftClockOut, rxShiftClockOe, rxFrameSyncOut, rxFrameSyncOe, txShiftClockOut;
  wire         txShiftClockOe, txSerialOut, txSerialOutOe, txFrameSyncOut, txFrameSyncOe;
  wire         pClk, pFs, pDat, gotFlag;
  wire  [15:0] gotWord;
  wire         rxShiftClockIn = rxShiftClockOe ? rxShiftClockOut : pClk;
  wire         rxFrameSyncIn = rxFrameSyncOe ? rxFrameSyncOut : pFs;
  wire         rxSerialIn = pDat;
  // released tx clock is pulled high until extTx is set, then it follows the peer clock
  wire         txShiftClockIn = txShiftClockOe ? txShiftClockOut : ~extTx | pClk;
  wire         txSerialOutIn = txSerialOutOe & txSerialOut;
  wire         txFrameSyncIn = txFrameSyncOe ? txFrameSyncOut : extTx & pFs;
  integer      errors = 0;
  integer      n_tests = 0;
  integer      k;
  logic [31:0] seed = 32'hD622CC2E;
  logic [65:0] rdQ[$];
  logic [15:0] txQ[$];
  logic [1:0]  bQ[$];
  logic        extTx = 1'b0;
  logic [15:0] w;

  always #10 ref_clk = ~ref_clk;

  bspp_top u_dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxShiftClockIn, .rxShiftClockOut, .rxShiftClockOe, .rxSerialIn,
    .rxFrameSyncIn, .rxFrameSyncOut, .rxFrameSyncOe, .txShiftClockIn, .txShiftClockOut,
    .txShiftClockOe, .txSerialOutIn, .txSerialOut, .txSerialOutOe, .txFrameSyncIn,
    .txFrameSyncOut, .txFrameSyncOe, .outputOffN);
  bspp_peer u_peer (.txClk(txShiftClockIn), .txFs(txFrameSyncIn), .txDat(txSerialOutIn),
    .rxClk(pClk), .rxFs(pFs), .rxDat(pDat), .gotWord, .gotFlag);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // bus tasks start and end just after a rising edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw, wd;
    aw = 1'b1;
    wd = 1'b1;
    bQ.push_back((a[4:2] > 3'h4) ? `BSPP_RESP_SLVERR : `BSPP_RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wd && s_axi_wready) begin
        wd = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [33:0] e);
    rdQ.push_back({m, e});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check("read", {s_axi_rresp, s_axi_rdata & rdQ[0][65:34]}, rdQ[0][33:0]);
      void'(rdQ.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      check("bresp", {32'h0, s_axi_bresp}, {32'h0, bQ.pop_front()});
    end
  end
  always @(posedge gotFlag) begin
    check("txword", {18'h0, gotWord}, {18'h0, txQ.pop_front()});
  end
  initial begin
    #400000;
    errors++;
    $display("watchdog expired");
    report_and_stop;
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    outputOffN = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`BSPP_ADDR_CLKDIV, 32'hFF, {`BSPP_RESP_OKAY, 24'h0, `BSPP_CLKDIV_RST});
    rd(5'h14, 32'hFFFFFFFF, {`BSPP_RESP_SLVERR, 32'h0});
    wr(5'h14, 32'hFFFFFFFF);
    rd(`BSPP_ADDR_PCR, 32'h00FFFFFF, 34'h0);
    $display("test registers done");
    wr(`BSPP_ADDR_CTRL, 32'h1);
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      w = seed[15:0];
      u_peer.send(w);
      repeat (8) @(posedge ref_clk);
      rd(`BSPP_ADDR_RXDATA, 32'hFFFF, {18'h0, w});
    end
    $display("test receive done");
    wr(`BSPP_ADDR_PCR, 32'h00113D30);
    repeat (4) @(posedge ref_clk);
    check("txpins", {28'h0, txShiftClockOe, txShiftClockOut, txSerialOutOe, txSerialOut,
      txFrameSyncOe, txFrameSyncOut}, 34'h2E);
    check("rxpins", {30'h0, rxShiftClockOe, rxShiftClockOut, rxFrameSyncOe,
      rxFrameSyncOut}, 34'hE);
    rd(`BSPP_ADDR_CTRL, 32'h30, 34'h20);
    rd(`BSPP_ADDR_PCR, 32'h3D000000, 34'h11000000);
    outputOffN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("offpins", {31'h0, txShiftClockOe, txSerialOutOe, txFrameSyncOe}, 34'h0);
    outputOffN <= 1'b1;
    wr(`BSPP_ADDR_PCR, 32'h1);
    repeat (4) @(posedge ref_clk);
    check("rxclkdrv", {33'h0, rxShiftClockOe}, 34'h1);
    rd(`BSPP_ADDR_CTRL, 32'h10, 34'h10);
    $display("test pins done");
    wr(`BSPP_ADDR_CTRL, 32'h0);
    wr(`BSPP_ADDR_PCR, 32'hA);
    for (k = 0; k < `BSPP_FIFO_DEPTH; k++) begin
      seed = xs(seed);
      txQ.push_back(seed[15:0]);
      wr(`BSPP_ADDR_TXDATA, seed);
    end
    rd(`BSPP_ADDR_CTRL, 32'h400, 34'h400);
    wr(`BSPP_ADDR_CTRL, 32'h2);
    for (k = 0; k < 6000 && txQ.size() != 0; k++) begin
      @(posedge ref_clk);
    end
    repeat (40) @(posedge ref_clk);
    check("drained", 34'(txQ.size()), 34'h0);
    rd(`BSPP_ADDR_CTRL, 32'h502, 34'h2);
    $display("test transmit done");
    check("fsdrv", {33'h0, txFrameSyncOe}, 34'h1);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("fsreset", {33'h0, txFrameSyncOe}, 34'h0);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`BSPP_ADDR_PCR, 32'h8, 34'h0);
    extTx <= 1'b1;
    wr(`BSPP_ADDR_CTRL, 32'h2);
    txQ.push_back(w);
    wr(`BSPP_ADDR_TXDATA, {16'h0, w});
    u_peer.send(w);
    check("txext", 34'(txQ.size()), 34'h0);
    $display("test reset done");
    report_and_stop;
  end
endmodule // bspp_top_test
